// file: shared/switch_ctrl_pkg.sv
// Constants for the on/off switch controller
package switch_ctrl_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int OSC_AVG_HZ = 66_000;
    localparam int OSC_JITTER_PP_HZ = 4_000;
    localparam int JITTER_RATE_HZ = 1_000;
    // Nominal and extreme cycle lengths in system clocks
    localparam int OSC_PERIOD_CYC = CLK_HZ / OSC_AVG_HZ;
    localparam int OSC_PERIOD_MIN_CYC =
        CLK_HZ / (OSC_AVG_HZ + OSC_JITTER_PP_HZ / 2);
    localparam int OSC_PERIOD_MAX_CYC =
        CLK_HZ / (OSC_AVG_HZ - OSC_JITTER_PP_HZ / 2);
    localparam int JITTER_SPAN_CYC = OSC_PERIOD_MAX_CYC - OSC_PERIOD_MIN_CYC;
    // Oscillator cycles per jitter sweep (one triangle, up then down)
    localparam int JITTER_SWEEP_CYCLES = OSC_AVG_HZ / JITTER_RATE_HZ;
    // Maximum duty window as a percentage of the cycle
    localparam int MAX_DUTY_PCT = 65;
    localparam int BLANK_TIME_NS = 220;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_CYC =
        (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_ON_MS = 50;
    localparam int RESTART_OFF_MS = 800;
    // Restart timer counts oscillator cycles (66 per millisecond)
    localparam int RESTART_ON_OSC = RESTART_ON_MS * (OSC_AVG_HZ / 1000);
    localparam int RESTART_OFF_OSC = RESTART_OFF_MS * (OSC_AVG_HZ / 1000);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic UV_LOCK_RESET = 1'b1;
    localparam logic THERMAL_LOCK_RESET = 1'b0;

    typedef enum logic [1:0] {
        RESTART_RUN,
        RESTART_HOLD
    } restart_state_type;

endpackage

// file: core/jitter_oscillator.sv
// Jittered switching-cycle oscillator with duty window
`timescale 1ns/1ns
`default_nettype none
module jitter_oscillator
    import switch_ctrl_pkg::*;
#(
    parameter int PERIOD_MIN = OSC_PERIOD_MIN_CYC,
    parameter int SPAN = JITTER_SPAN_CYC,
    parameter int SWEEP = JITTER_SWEEP_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Cycle outputs
    output logic o_cycle_start,
    output logic o_max_duty_window
);
    // Period, window and sweep counters are only 16 bits wide
    if (PERIOD_MIN < 4 || SPAN < 0 || SWEEP < 2 || SWEEP > 65535 ||
        PERIOD_MIN + SPAN > 65535) begin : g_bad_params
        $error("jitter_oscillator: unusable parameters");
    end

    localparam int HALF = SWEEP / 2;

    logic [15:0] count_reg;
    logic [15:0] period_reg;
    logic [15:0] window_reg;
    logic [15:0] sweep_reg;
    logic [15:0] offset;

    // ------------------------------------------------------------
    // Triangle sweep of the period offset
    // ------------------------------------------------------------
    always_comb begin
        if (sweep_reg < 16'(HALF)) begin
            offset = 16'((int'(sweep_reg) * SPAN) / HALF);
        end else begin
            offset = 16'(((SWEEP - int'(sweep_reg)) * SPAN) / HALF);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            count_reg <= 16'h0000;
            period_reg <= 16'(PERIOD_MIN);
            window_reg <= 16'(PERIOD_MIN * MAX_DUTY_PCT / 100);
            sweep_reg <= 16'h0000;
            o_cycle_start <= 1'b0;
        end else if (count_reg >= period_reg - 16'h0001) begin
            // New cycle: load period for the next sweep step
            count_reg <= 16'h0000;
            period_reg <= 16'(PERIOD_MIN) + offset;
            window_reg <= 16'((int'(16'(PERIOD_MIN) + offset)
                               * MAX_DUTY_PCT) / 100);
            sweep_reg <= (sweep_reg >= 16'(SWEEP - 1)) ? 16'h0000
                                                       : sweep_reg + 16'h0001;
            o_cycle_start <= 1'b1;
        end else begin
            count_reg <= count_reg + 16'h0001;
            o_cycle_start <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_max_duty_window <= 1'b0;
        end else begin
            // Window opens with the cycle and closes at the duty limit
            o_max_duty_window <= (count_reg >= period_reg - 16'h0001) ||
                                 (count_reg + 16'h0001 < window_reg);
        end
    end
endmodule // jitter_oscillator
`default_nettype wire

// file: core/on_off_switch_controller.sv
// On/off power switch controller top level
`timescale 1ns/1ns
`default_nettype none
module on_off_switch_controller
    import switch_ctrl_pkg::*;
#(
    parameter int RESTART_ON = RESTART_ON_OSC,
    parameter int RESTART_OFF = RESTART_OFF_OSC,
    parameter int BLANK = BLANK_CYC,
    parameter bit AUTO_RESTART = 1'b1
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Analog comparator flags (asynchronous)
    input wire logic i_feedback_enable,
    input wire logic i_regulation_sense_high,
    input wire logic i_over_current,
    input wire logic i_supply_under,
    input wire logic i_supply_regulated,
    input wire logic i_temp_over,
    input wire logic i_temp_cooled,
    // Switch and regulator control
    output logic o_switch_gate,
    output logic o_supply_charge_en,
    output logic o_switching_allowed
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Restart counter is 16 bits and the blanking counter 8 bits
    if (RESTART_ON < 1 || RESTART_OFF < 1 || BLANK < 1 ||
        RESTART_ON > 65535 || RESTART_OFF > 65535 ||
        BLANK > 255) begin : g_bad_params
        $error("on_off_switch_controller: unusable parameters");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic fb_en;
    logic sense_high;
    logic over_current;
    logic supply_under;
    logic supply_ok;
    logic temp_over;
    logic temp_cooled;
    // Flags come from unclocked comparators, so two flops each

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_feedback_enable, i_regulation_sense_high,
                          i_over_current, i_supply_under,
                          i_supply_regulated, i_temp_over, i_temp_cooled};
            sync2_reg <= sync1_reg;
        end
    end

    // Feedback enable high means sense current is under threshold
    assign {fb_en, sense_high, over_current, supply_under,
            supply_ok, temp_over, temp_cooled} = sync2_reg;

    // ------------------------------------------------------------
    // Oscillator
    // ------------------------------------------------------------
    logic cycle_start;
    logic duty_window;

    jitter_oscillator u_osc (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .o_cycle_start(cycle_start),
        .o_max_duty_window(duty_window)
    );

    // ------------------------------------------------------------
    // Protection latches
    // ------------------------------------------------------------
    logic uv_lock_reg;
    logic thermal_lock_reg;
    // Both latches hold until the matching release flag is seen

    // Starts locked so the switch waits for a regulated supply
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            uv_lock_reg <= UV_LOCK_RESET;
        end else if (supply_under) begin
            uv_lock_reg <= 1'b1;
        end else if (supply_ok) begin
            uv_lock_reg <= 1'b0;
        end
    end

    // Trip wins over release if both flags glitch together
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            thermal_lock_reg <= THERMAL_LOCK_RESET;
        end else if (temp_over) begin
            thermal_lock_reg <= 1'b1;
        end else if (temp_cooled) begin
            thermal_lock_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Auto-restart timer, counted in oscillator cycles
    // ------------------------------------------------------------
    restart_state_type restart_state_reg;
    logic [15:0] restart_count_reg;
    logic restart_block;
    // A sense input stuck low means an open loop or a short

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !AUTO_RESTART) begin
            restart_state_reg <= RESTART_RUN;
            restart_count_reg <= 16'h0000;
        end else begin
            case (restart_state_reg)
                RESTART_RUN: begin
                    if (sense_high) begin
                        restart_count_reg <= 16'h0000;
                    end else if (cycle_start) begin
                        if (restart_count_reg >= 16'(RESTART_ON - 1)) begin
                            restart_state_reg <= RESTART_HOLD;
                            restart_count_reg <= 16'h0000;
                        end else begin
                            restart_count_reg <= restart_count_reg + 16'h0001;
                        end
                    end
                end
                RESTART_HOLD: begin
                    // Hold time runs regardless of feedback
                    if (cycle_start) begin
                        if (restart_count_reg >= 16'(RESTART_OFF - 1)) begin
                            restart_state_reg <= RESTART_RUN;
                            restart_count_reg <= 16'h0000;
                        end else begin
                            restart_count_reg <= restart_count_reg + 16'h0001;
                        end
                    end
                end
                default: begin
                    restart_state_reg <= RESTART_RUN;
                    restart_count_reg <= 16'h0000;
                end
            endcase
        end
    end

    assign restart_block = (restart_state_reg == RESTART_HOLD);

    // ------------------------------------------------------------
    // Enable summary
    // ------------------------------------------------------------
    logic allowed;
    assign allowed = !uv_lock_reg && !thermal_lock_reg && !restart_block;
    // Registered copy for the outside; the gate reacts to the live summary

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_switching_allowed <= 1'b0;
        end else begin
            o_switching_allowed <= allowed;
        end
    end

    // ------------------------------------------------------------
    // Cycle gate control
    // ------------------------------------------------------------
    logic [7:0] blank_reg;
    logic gate_next;
    // Gate is a flop so the switch never sees a decode glitch

    // Feedback is looked at only on cycle_start, so later edges are ignored
    always_comb begin
        gate_next = o_switch_gate;
        if (cycle_start) begin
            gate_next = fb_en && allowed;
        end else if (!allowed) begin
            gate_next = 1'b0;
        end else if (!duty_window) begin
            gate_next = 1'b0;
        end else if (over_current && blank_reg == 8'h00) begin
            gate_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_switch_gate <= 1'b0;
        end else begin
            o_switch_gate <= gate_next;
        end
    end

    // Blanking restarts at each turn-on; synchroniser delay adds margin
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            blank_reg <= 8'h00;
        end else if (gate_next && !o_switch_gate) begin
            blank_reg <= 8'(BLANK);
        end else if (blank_reg != 8'h00) begin
            blank_reg <= blank_reg - 8'h01;
        end
    end

    // Regulator recharges the supply node only while the switch is off
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_supply_charge_en <= 1'b1;
        end else begin
            o_supply_charge_en <= !gate_next;
        end
    end
endmodule // on_off_switch_controller
`default_nettype wire

// file: sim/switch_ctrl_assertions.sv
// Port checker for the on/off switch controller
`timescale 1ns/1ns
`default_nettype none
module switch_ctrl_checker #(
    parameter int BLANK = 22
) (
    // Clock, reset and flags
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_feedback_enable,
    input wire logic i_over_current,
    input wire logic i_supply_under,
    input wire logic i_temp_over,
    // Controller outputs
    input wire logic o_switch_gate,
    input wire logic o_supply_charge_en,
    input wire logic o_switching_allowed
);
    // ------
    // Pulse length and spacing counters
    // ------
    int hi_cnt;
    int gap_cnt;
    always_ff @(posedge i_clk_sys) begin
        hi_cnt <= (i_reset || !o_switch_gate) ? 0 : hi_cnt + 1;
    end
    always_ff @(posedge i_clk_sys) begin
        gap_cnt <= i_reset ? 0 :
            (o_switch_gate && hi_cnt == 0) ? 1 : gap_cnt + 1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    charge_when_off_a: assert property (
        o_supply_charge_en == !o_switch_gate)
        else $error("charge enable not inverse of gate");
    rise_needs_allow_a: assert property (
        o_switch_gate && hi_cnt == 0 |-> o_switching_allowed)
        else $error("gate rose while locked");
    rise_needs_fb_a: assert property (
        o_switch_gate && hi_cnt == 0 |-> $past(i_feedback_enable, 2)
        || $past(i_feedback_enable, 3) || $past(i_feedback_enable, 4))
        else $error("gate rose without feedback enable");
    one_per_cycle_a: assert property (
        o_switch_gate && hi_cnt == 0 |-> gap_cnt >= 1400)
        else $error("pulses closer than one cycle");
    duty_limit_a: assert property (
        o_switch_gate |-> hi_cnt < 1020)
        else $error("pulse longer than duty window");
    blank_min_a: assert property (
        !o_switch_gate && hi_cnt > 0 && o_switching_allowed
        |-> hi_cnt >= BLANK)
        else $error("pulse ended inside blanking");
    limit_ends_a: assert property (
        o_switch_gate && i_over_current && hi_cnt >= BLANK + 3
        |-> ##[1:6] !o_switch_gate)
        else $error("over current did not end pulse");
    uv_disable_a: assert property (
        i_supply_under |-> ##[1:5] !o_switching_allowed)
        else $error("undervoltage did not lock");
    hot_disable_a: assert property (
        i_temp_over |-> ##[1:5] !o_switching_allowed)
        else $error("over temperature did not lock");
endmodule // switch_ctrl_checker
bind on_off_switch_controller switch_ctrl_checker #(.BLANK(BLANK)) u_chk (
    .i_clk_sys, .i_reset, .i_feedback_enable, .i_over_current,
    .i_supply_under, .i_temp_over, .o_switch_gate, .o_supply_charge_en,
    .o_switching_allowed);
`default_nettype wire

// file: sim/switch_front_model.sv
// Analog sense comparators and power switch model
`timescale 1ns/1ns
`default_nettype none
module switch_front_model (
    // Clock and gate
    input wire logic i_clk_sys,
    input wire logic i_gate,
    // Load knobs
    input wire logic i_load_over,
    input wire logic [15:0] i_ramp,
    // Comparator flags
    output logic o_feedback_enable,
    output logic o_over_current
);
    int on_cnt;
    // Sense current above threshold pulls the enable low
    assign o_feedback_enable = !i_load_over;
    // Current ramps while on and collapses at once when off
    always_ff @(posedge i_clk_sys) begin
        on_cnt <= i_gate ? on_cnt + 1 : 0;
    end
    assign o_over_current = i_gate && (on_cnt >= int'(i_ramp));
endmodule // switch_front_model
`default_nettype wire

// file: sim/tb_on_off_switch_controller.sv
// Testbench for the on/off switch controller
`timescale 1ns/1ns
`default_nettype none
module tb_on_off_switch_controller;
    typedef struct packed {
        logic load;
        logic [15:0] ramp;
        logic found;
        logic [15:0] lo;
        logic [15:0] hi;
    } row_type;
    // Full duty, late limit, limit inside blanking, skipped cycle
    localparam row_type ROWS [4] = '{
        '{1'b0, 16'h07D0, 1'b1, 16'h03B6, 16'h03FC},
        '{1'b0, 16'h0064, 1'b1, 16'h0064, 16'h006E},
        '{1'b0, 16'h0005, 1'b1, 16'h0016, 16'h0020},
        '{1'b1, 16'h07D0, 1'b0, 16'h0000, 16'h0000}};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic load = 1'b0;
    logic sense_high = 1'b1;
    logic under = 1'b0;
    logic regulated = 1'b0;
    logic hot = 1'b0;
    logic cooled = 1'b1;
    logic [15:0] ramp = 16'h07D0;
    logic fb_en, oc, gate, charge, allowed, found;
    int error_cnt = 0;
    int total_checks = 0;
    int len;
    int len2;
    always #5 clk_sys = ~clk_sys;
    on_off_switch_controller #(.RESTART_ON(3), .RESTART_OFF(5)) uut (
        .i_clk_sys(clk_sys), .i_reset(reset), .i_feedback_enable(fb_en),
        .i_regulation_sense_high(sense_high), .i_over_current(oc),
        .i_supply_under(under), .i_supply_regulated(regulated),
        .i_temp_over(hot), .i_temp_cooled(cooled), .o_switch_gate(gate),
        .o_supply_charge_en(charge), .o_switching_allowed(allowed));
    switch_front_model partner (
        .i_clk_sys(clk_sys), .i_gate(gate), .i_load_over(load),
        .i_ramp(ramp), .o_feedback_enable(fb_en), .o_over_current(oc));
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // Finds a fresh rising gate and measures its length
    task automatic pulse(input logic drop, output logic got, output int n);
        logic low;
        low = 1'b0;
        got = 1'b0;
        n = 0;
        repeat (1700) begin
            @(negedge clk_sys);
            if (gate !== 1'b1) low = 1'b1;
            else if (low) begin
                got = 1'b1;
                break;
            end
        end
        load = drop;
        if (got) check(charge, 1'b0);
        while (got && gate === 1'b1 && n < 1200) begin
            @(negedge clk_sys);
            n++;
        end
        if (got && gate === 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: pulse ran on", $time);
            end_sim();
        end
    endtask
    task automatic wait_allow(input logic v, input int bound, output int n);
        n = 0;
        while (allowed !== v) begin
            @(negedge clk_sys);
            n++;
            if (n > bound) begin
                error_cnt++;
                $display("wrong value at %0t: wait ran out", $time);
                end_sim();
            end
        end
    endtask
    initial begin
        repeat (4) @(negedge clk_sys);
        check(gate, 1'b0);
        check(charge, 1'b1);
        check(allowed, 1'b0);
        reset = 1'b0;
        repeat (20) @(negedge clk_sys);
        check(allowed, 1'b0);
        regulated = 1'b1;
        wait_allow(1'b1, 8, len);
        for (int i = 0; i < 4; i++) begin
            load = ROWS[i].load;
            ramp = ROWS[i].ramp;
            repeat (1600) @(negedge clk_sys);
            pulse(ROWS[i].load, found, len);
            check(found, ROWS[i].found);
            check(len >= ROWS[i].lo && len <= ROWS[i].hi, 1'b1);
        end
        load = 1'b0;
        ramp = 16'h07D0;
        repeat (1600) @(negedge clk_sys);
        pulse(1'b0, found, len);
        pulse(1'b1, found, len2);
        check(len != len2, 1'b1);
        check(len - len2 <= 2 && len2 - len <= 2, 1'b1);
        check(len2 >= 950, 1'b1);
        pulse(1'b0, found, len);
        check(found, 1'b0);
        under = 1'b1;
        regulated = 1'b0;
        wait_allow(1'b0, 6, len);
        under = 1'b0;
        repeat (3200) @(negedge clk_sys);
        check(allowed, 1'b0);
        regulated = 1'b1;
        wait_allow(1'b1, 8, len);
        hot = 1'b1;
        cooled = 1'b0;
        wait_allow(1'b0, 6, len);
        hot = 1'b0;
        repeat (3200) @(negedge clk_sys);
        check(allowed, 1'b0);
        cooled = 1'b1;
        wait_allow(1'b1, 8, len);
        sense_high = 1'b0;
        wait_allow(1'b0, 8000, len);
        wait_allow(1'b1, 9000, len);
        check(len >= 7300 && len <= 7900, 1'b1);
        sense_high = 1'b1;
        repeat (8000) @(negedge clk_sys);
        check(allowed, 1'b1);
        end_sim();
    end
endmodule // tb_on_off_switch_controller
`default_nettype wire
